// ---- logic/cet_ctrl.sv ----
`timescale 1ns/1ps
// Summary of operation
// - after reset every bank has corrected-error signalling switched off.
// - capability bit 10 reads one, signalling is supported.
// - each supported bank control register enables signalling and holds that bank's threshold.
// - signalling ignores the exception enable flag and bank error control.
// - supported banks read threshold bits back; unsupported banks read zero.
// - enable bit 30 sticks only in supported banks; others read zero.
// - delivery is set by the vector entry at offset 2F0H.
// - shared-structure errors interrupt every logical processor sharing it.
// - package-level errors may interrupt every logical processor.
// - system-level errors never raise the corrected-error interrupt.
// - threshold field accepts writes; implemented bits compare against status count.
// - threshold one raises an interrupt on every corrected error.
// - writing 7FFFH reads back the largest supported threshold.
// - capability bits 7:0 give the number of banks.
// - one shared enable bit per bank seen by all processors.
// - status bit 63 marks a valid logged error.
// - after software clears status the bank logs new errors.
module cet_ctrl
  import cet_pkg::*;
(
  input  wire logic     i_sys_clk,
  input  wire logic     i_arst_n,
  input  wire cet_req_s i_req,
  input  wire cet_err_s i_err,
  output cet_rsp_s      o_rsp,
  output cet_irq_s      o_irq
);

  cet_st_s st_r;
  cet_st_s st_nxt;

  function automatic logic [NUM_LP-1:0] lp_targets(
    input cet_scope_e        scope,
    input logic [BANK_W-1:0] bank,
    input logic [LP_W-1:0]   lp
  );
    logic [NUM_LP-1:0] t;
    t = '0;
    case (scope)
      CET_SCOPE_CORE:   t[lp] = 1'b1;
      CET_SCOPE_SHARED: t = BANK_SHARE[bank];
      CET_SCOPE_PKG:    t = '1;
      default:          t = '0;
    endcase
    return t;
  endfunction

  function automatic logic [DATA_W-1:0] rd_mux(
    input cet_st_s  s,
    input cet_req_s q
  );
    logic [DATA_W-1:0] d;
    d = '0;
    case (q.sel)
      CET_SEL_CAP: begin
        d[CAP_CNT_LSB +: CAP_CNT_W] = CAP_CNT_W'(NUM_BANKS);
        d[CAP_CORRECTED_ERROR_INTERRUPT_BIT]             = 1'b1;
      end
      CET_SEL_CTL2: begin
        // upper threshold bits and bit 15 stay zero
        d[CTL2_EN_BIT]        = s.bank[q.bank].en;
        d[THR_IMPL-1:0]       = s.bank[q.bank].thr;
      end
      CET_SEL_STATUS: begin
        d[STAT_VALID_BIT]           = s.bank[q.bank].valid;
        d[STAT_CNT_LSB +: CNT_W]    = s.bank[q.bank].cnt;
      end
      CET_SEL_ECTL: d = s.bank[q.bank].ectl;
      CET_SEL_APIC: begin
        if (q.addr == VEC_OFFSET) begin
          d[VEC_W-1:0] = s.vec;
        end
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  always_comb begin
    cet_bank_s nb;
    nb = '0;
    st_nxt = st_r;
    st_nxt.rsp.valid = 1'b0;
    st_nxt.irq.lp = '0;

    if (i_req.rd) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.data  = rd_mux(st_r, i_req);
    end

    if (i_req.wr) begin
      case (i_req.sel)
        CET_SEL_CTL2: begin
          // one copy per bank, so every sharing processor sees it
          if (BANK_SUPPORTS[i_req.bank]) begin
            st_nxt.bank[i_req.bank].en  = i_req.wdata[CTL2_EN_BIT];
            st_nxt.bank[i_req.bank].thr = i_req.wdata[THR_IMPL-1:0];
          end
        end
        CET_SEL_STATUS: begin
          st_nxt.bank[i_req.bank].valid = i_req.wdata[STAT_VALID_BIT];
          st_nxt.bank[i_req.bank].cnt   = i_req.wdata[STAT_CNT_LSB +: CNT_W];
        end
        CET_SEL_ECTL: st_nxt.bank[i_req.bank].ectl = i_req.wdata;
        CET_SEL_APIC: begin
          if (i_req.addr == VEC_OFFSET) begin
            st_nxt.vec = i_req.wdata[VEC_W-1:0];
          end
        end
        default: ;
      endcase
    end

    // logged after the software write, so an error in the clearing cycle is kept
    if (i_err.valid && i_err.scope != CET_SCOPE_SYS) begin
      nb = st_nxt.bank[i_err.bank];
      nb.valid = 1'b1;
      if (nb.cnt != CNT_MAX) begin
        nb.cnt = nb.cnt + CNT_ONE;
      end
      st_nxt.bank[i_err.bank] = nb;
      // error control and exception enable play no part here
      if (nb.en && nb.thr != THR_ZERO &&
          nb.cnt >= {{(CNT_W-THR_IMPL){1'b0}}, nb.thr} &&
          !st_nxt.vec[VEC_MASK_BIT]) begin
        st_nxt.irq.lp  = lp_targets(i_err.scope, i_err.bank, i_err.lp);
        st_nxt.irq.vec = st_nxt.vec[VNUM_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r     <= '0;
      st_r.vec <= VEC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rsp = st_r.rsp;
  assign o_irq = st_r.irq;

  sequence s_ctl2_wr_sup;
    i_req.wr && i_req.sel == CET_SEL_CTL2 && BANK_SUPPORTS[i_req.bank];
  endsequence

  sequence s_ctl2_rd_same;
    i_req.rd && !i_req.wr && i_req.sel == CET_SEL_CTL2 && i_req.bank == $past(i_req.bank);
  endsequence

  sequence s_err_live;
    i_err.valid && i_err.scope != CET_SCOPE_SYS;
  endsequence

  property p_thr_readback;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_ctl2_wr_sup ##1 s_ctl2_rd_same |=>
      o_rsp.data[THR_IMPL-1:0] == $past(i_req.wdata[THR_IMPL-1:0], 2) &&
      o_rsp.data[CTL2_EN_BIT] == $past(i_req.wdata[CTL2_EN_BIT], 2);
  endproperty

  a_en_needs_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    $rose(st_r.bank[0].en) |->
      $past(i_req.wr) && $past(i_req.sel) == CET_SEL_CTL2 && $past(i_req.bank) == '0)
    else $error("bank enable rose without a control write");

  a_cap_fields: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_req.rd && i_req.sel == CET_SEL_CAP |=>
      o_rsp.valid && o_rsp.data[CAP_CORRECTED_ERROR_INTERRUPT_BIT] &&
      o_rsp.data[CAP_CNT_LSB +: CAP_CNT_W] == CAP_CNT_W'(NUM_BANKS))
    else $error("capability read wrong");

  a_thr_readback: assert property (p_thr_readback)
    else $error("threshold or enable did not read back");

  a_unsup_zero: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_req.rd && i_req.sel == CET_SEL_CTL2 && !BANK_SUPPORTS[i_req.bank] |=>
      o_rsp.data == '0)
    else $error("unsupported bank control not zero");

  a_sys_silent: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_err.valid && i_err.scope == CET_SCOPE_SYS |=> o_irq.lp == '0)
    else $error("system error raised interrupt");

  a_thr_one: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_err_live and (!i_req.wr && st_r.bank[i_err.bank].en &&
      st_r.bank[i_err.bank].thr == THR_IMPL'(1) && !st_r.vec[VEC_MASK_BIT])
      |=> o_irq.lp != '0 && o_irq.vec == st_r.vec[VNUM_W-1:0])
    else $error("threshold one error gave no interrupt");

  a_irq_cause: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    o_irq.lp != '0 |->
      $past(i_err.valid) && st_r.bank[$past(i_err.bank)].valid &&
      st_r.bank[$past(i_err.bank)].cnt >= {{(CNT_W-THR_IMPL){1'b0}}, st_r.bank[$past(i_err.bank)].thr})
    else $error("interrupt without enabled overflow");

  a_status_log: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_err_live |=> st_r.bank[$past(i_err.bank)].valid)
    else $error("error not logged as valid");

  a_shared_all: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    ##1 o_irq.lp != '0 && $past(i_err.scope) == CET_SCOPE_SHARED |->
      o_irq.lp == BANK_SHARE[$past(i_err.bank)])
    else $error("shared error missed a sharing processor");

  a_pkg_all: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    ##1 o_irq.lp != '0 && $past(i_err.scope) == CET_SCOPE_PKG |-> &o_irq.lp)
    else $error("package error missed a processor");

  a_irq_pulse: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    o_irq.lp != '0 && !i_err.valid |=> o_irq.lp == '0)
    else $error("interrupt held without a new error");

  // building blocks for the checks below
  sequence s_ctl2_rd;
    i_req.rd && i_req.sel == CET_SEL_CTL2;
  endsequence

  sequence s_stat_rd;
    i_req.rd && i_req.sel == CET_SEL_STATUS;
  endsequence

  sequence s_apic_other_rd;
    i_req.rd && i_req.sel == CET_SEL_APIC && i_req.addr != VEC_OFFSET;
  endsequence

  sequence s_vec_wr;
    i_req.wr && i_req.sel == CET_SEL_APIC && i_req.addr == VEC_OFFSET;
  endsequence

  a_rsp_pulse: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    !i_req.rd |=> !o_rsp.valid)
    else $error("read answer without a read");

  a_ctl2_shape: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_ctl2_rd |=> o_rsp.valid && o_rsp.data[DATA_W-1:CTL2_EN_BIT+1] == '0 &&
      o_rsp.data[CTL2_EN_BIT-1:THR_IMPL] == '0)
    else $error("control read shows unimplemented bits");

  a_stat_shape: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_stat_rd |=> o_rsp.valid && o_rsp.data[STAT_VALID_BIT-1:STAT_CNT_LSB+CNT_W] == '0 &&
      o_rsp.data[STAT_CNT_LSB-1:0] == '0)
    else $error("status read shows stray bits");

  a_apic_other: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_apic_other_rd |=> o_rsp.data == '0)
    else $error("unmapped interrupt-unit offset not zero");

  // unsupported banks must never hold an enable or a threshold
  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_unsup
    if (!BANK_SUPPORTS[g]) begin : g_chk
      a_unsup_hold: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !st_r.bank[g].en && st_r.bank[g].thr == THR_ZERO)
        else $error("unsupported bank holds control state");
    end
  end

  a_disabled_quiet: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_err_live and (!i_req.wr && !st_r.bank[i_err.bank].en) |=> o_irq.lp == '0)
    else $error("disabled bank raised interrupt");

  a_thr_zero_quiet: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_err_live and (!i_req.wr && st_r.bank[i_err.bank].thr == THR_ZERO) |=> o_irq.lp == '0)
    else $error("zero threshold raised interrupt");

  a_masked_quiet: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    st_r.vec[VEC_MASK_BIT] && !i_req.wr |=> o_irq.lp == '0)
    else $error("masked entry delivered interrupt");

  // a status write in the same cycle reloads the count, so it is left out here
  a_cnt_inc: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_err_live and (!(i_req.wr && i_req.sel == CET_SEL_STATUS) && st_r.bank[i_err.bank].cnt != CNT_MAX)
      |=> st_r.bank[$past(i_err.bank)].cnt == $past(st_r.bank[i_err.bank].cnt) + CNT_ONE)
    else $error("error count did not advance");

  a_cnt_sat: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_err_live and (!i_req.wr && st_r.bank[i_err.bank].cnt == CNT_MAX)
      |=> st_r.bank[$past(i_err.bank)].cnt == CNT_MAX)
    else $error("error count wrapped");

  a_core_target: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    ##1 o_irq.lp != '0 && $past(i_err.scope) == CET_SCOPE_CORE |->
      o_irq.lp == (NUM_LP'(1) << $past(i_err.lp)))
    else $error("core error sent to wrong processor");

  a_status_clear: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_req.wr && i_req.sel == CET_SEL_STATUS && !i_req.wdata[STAT_VALID_BIT] && !i_err.valid
      |=> !st_r.bank[$past(i_req.bank)].valid)
    else $error("status clear did not take");

  a_ectl_free: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_req.wr && i_req.sel == CET_SEL_ECTL |=>
      st_r.bank[$past(i_req.bank)].en == $past(st_r.bank[i_req.bank].en))
    else $error("error control write moved enable");

  a_vec_hold: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    not s_vec_wr |=> $stable(st_r.vec))
    else $error("vector entry changed without a write");

  a_irq_vec_hold: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    $changed(o_irq.vec) |-> o_irq.lp != '0)
    else $error("delivery vector moved between pulses");

  // the implemented threshold bits are kept exactly as written
  a_thr_impl: assert property (
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    s_ctl2_wr_sup |=> st_r.bank[$past(i_req.bank)].thr == $past(i_req.wdata[THR_IMPL-1:0]))
    else $error("implemented threshold not stored");

endmodule

// ---- logic/cet_pkg.sv ----
package cet_pkg;
  localparam int NUM_BANKS  = 4;
  localparam int NUM_LP     = 2;
  localparam int BANK_W     = 2;
  localparam int LP_W       = 1;
  // implemented threshold width, narrower than the 15-bit field on purpose
  localparam int THR_IMPL   = 12;
  localparam int CNT_W      = 15;
  localparam int DATA_W     = 64;
  localparam int VEC_W      = 32;
  localparam int VNUM_W     = 8;
  localparam int ADDR_W     = 12;

  localparam logic [NUM_BANKS-1:0] BANK_SUPPORTS = 4'h7;
  // logical processors that share each bank's structure
  localparam logic [NUM_LP-1:0] BANK_SHARE [NUM_BANKS] = '{2'h3, 2'h1, 2'h2, 2'h3};

  localparam int CAP_CNT_LSB    = 0;
  localparam int CAP_CNT_W      = 8;
  localparam int CAP_CORRECTED_ERROR_INTERRUPT_BIT   = 10;
  localparam int CTL2_EN_BIT    = 30;
  localparam int STAT_VALID_BIT = 63;
  localparam int STAT_CNT_LSB   = 38;
  localparam int VEC_MASK_BIT   = 16;

  localparam logic [ADDR_W-1:0]  VEC_OFFSET = 12'h2f0;
  localparam logic [VEC_W-1:0]   VEC_RESET  = 32'h0001_0000;
  localparam logic [CNT_W-1:0]   CNT_MAX    = 15'h7fff;
  localparam logic [CNT_W-1:0]   CNT_ONE    = 15'h0001;
  localparam logic [THR_IMPL-1:0] THR_ZERO  = 12'h000;

  typedef enum logic [2:0] {
    CET_SEL_CAP,
    CET_SEL_CTL2,
    CET_SEL_STATUS,
    CET_SEL_ECTL,
    CET_SEL_APIC
  } cet_sel_e;

  typedef enum logic [1:0] {
    CET_SCOPE_CORE,
    CET_SCOPE_SHARED,
    CET_SCOPE_PKG,
    CET_SCOPE_SYS
  } cet_scope_e;

  typedef struct packed {
    logic              rd;
    logic              wr;
    cet_sel_e          sel;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cet_req_s;

  typedef struct packed {
    logic              valid;
    logic [BANK_W-1:0] bank;
    cet_scope_e        scope;
    logic [LP_W-1:0]   lp;
  } cet_err_s;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } cet_rsp_s;

  typedef struct packed {
    logic [NUM_LP-1:0] lp;
    logic [VNUM_W-1:0] vec;
  } cet_irq_s;

  typedef struct packed {
    logic                en;
    logic [THR_IMPL-1:0] thr;
    logic                valid;
    logic [CNT_W-1:0]    cnt;
    logic [DATA_W-1:0]   ectl;
  } cet_bank_s;

  typedef struct packed {
    cet_bank_s [NUM_BANKS-1:0] bank;
    logic [VEC_W-1:0]          vec;
    cet_rsp_s                  rsp;
    cet_irq_s                  irq;
  } cet_st_s;
endpackage

// ---- test/cet_lp_model.sv ----
`timescale 1ns/1ps
// stands in for the logical processors' interrupt units; each counts the pulses it accepts
module cet_lp_model
  import cet_pkg::*;
(
  input  wire logic     i_sys_clk,
  input  wire logic     i_arst_n,
  input  wire cet_irq_s i_irq,
  output int            o_cnt [NUM_LP]
);
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < NUM_LP; i++)
        o_cnt[i] <= 0;
    end else begin
      // a pulse is one cycle wide, so each high sample is one delivery
      for (int i = 0; i < NUM_LP; i++)
        if (i_irq.lp[i] === 1'b1)
          o_cnt[i] <= o_cnt[i] + 1;
    end
  end
endmodule

// ---- test/corrected_error_threshold_interrupt_bench.sv ----
`timescale 1ns/1ps
module corrected_error_threshold_interrupt_bench;
  import cet_pkg::*;
  logic     i_sys_clk;
  logic     i_arst_n;
  cet_req_s i_req;
  cet_err_s i_err;
  cet_rsp_s o_rsp;
  cet_irq_s o_irq;
  int       lp_cnt [NUM_LP];
  int       exp_cnt [NUM_LP];
  int       n_fail;
  int       n_tests;

  cet_ctrl dut_u (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_req     (i_req),
    .i_err     (i_err),
    .o_rsp     (o_rsp),
    .o_irq     (o_irq)
  );

  cet_lp_model lp_u (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_irq     (o_irq),
    .o_cnt     (lp_cnt)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one strobe cycle; the answer is registered, so it stands only in the cycle after the strobe
  task automatic acc(input logic rd, input logic wr, input cet_sel_e sel, input logic [1:0] bank,
                     input logic [11:0] addr, input logic [63:0] wdata, output logic [63:0] q);
    @(negedge i_sys_clk);
    i_req = '{rd, wr, sel, bank, addr, wdata};
    @(negedge i_sys_clk);
    q = (o_rsp.valid === 1'b1) ? o_rsp.data : 64'hx;
    i_req.rd = 1'b0;
    i_req.wr = 1'b0;
  endtask

  task automatic wr(input cet_sel_e sel, input logic [1:0] bank, input logic [11:0] addr, input logic [63:0] d);
    logic [63:0] q;
    acc(1'b0, 1'b1, sel, bank, addr, d, q);
  endtask

  task automatic rd(input string what, input cet_sel_e sel, input logic [1:0] bank, input logic [11:0] addr,
                    input logic [63:0] exp);
    logic [63:0] q;
    acc(1'b1, 1'b0, sel, bank, addr, 64'h0, q);
    chk(what, exp, q);
  endtask

  // control write followed at once by a read of the same bank
  task automatic wr_rd(input string what, input logic [1:0] bank, input logic [63:0] d, input logic [63:0] exp);
    @(negedge i_sys_clk);
    i_req = '{1'b0, 1'b1, CET_SEL_CTL2, bank, 12'h0, d};
    @(negedge i_sys_clk);
    i_req.wr = 1'b0;
    i_req.rd = 1'b1;
    @(negedge i_sys_clk);
    chk(what, exp, (o_rsp.valid === 1'b1) ? o_rsp.data : 64'hx);
    i_req.rd = 1'b0;
  endtask

  // one error pulse, then the delivery mask seen one cycle later
  task automatic ev(input logic [1:0] bank, input cet_scope_e scope, input logic lp, input logic [1:0] exp_lp);
    @(negedge i_sys_clk);
    i_err = '{1'b1, bank, scope, lp};
    @(negedge i_sys_clk);
    i_err.valid = 1'b0;
    chk("irq targets", {62'h0, exp_lp}, {62'h0, o_irq.lp});
    for (int i = 0; i < NUM_LP; i++)
      exp_cnt[i] += int'(exp_lp[i]);
    if (exp_lp != 2'h0) begin
      chk("irq vector", 64'h40, {56'h0, o_irq.vec});
    end
  endtask

  initial begin
    i_req = '0;
    i_err = '0;
    i_arst_n = 1'b0;
    n_fail = 0;
    n_tests = 0;
    exp_cnt = '{0, 0};
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_arst_n = 1'b1;
    rd("capability", CET_SEL_CAP, 2'h0, 12'h0, 64'h404);
    rd("vector reset", CET_SEL_APIC, 2'h0, VEC_OFFSET, 64'h1_0000);
    for (int b = 0; b < NUM_BANKS; b++) begin
      rd("enable after reset", CET_SEL_CTL2, b[1:0], 12'h0, 64'h0);
      wr(CET_SEL_CTL2, b[1:0], 12'h0, 64'h4000_7fff);
      rd("discovery", CET_SEL_CTL2, b[1:0], 12'h0, BANK_SUPPORTS[b] ? 64'h4000_0fff : 64'h0);
    end
    wr(CET_SEL_CTL2, 2'h0, 12'h0, 64'h4000_ffff);
    rd("threshold field", CET_SEL_CTL2, 2'h0, 12'h0, 64'h4000_0fff);
    wr(CET_SEL_APIC, 2'h0, VEC_OFFSET, 64'h40);
    rd("vector", CET_SEL_APIC, 2'h0, VEC_OFFSET, 64'h40);
    wr(CET_SEL_APIC, 2'h0, 12'h2f4, 64'h55);
    rd("other offset", CET_SEL_APIC, 2'h0, 12'h2f4, 64'h0);
    wr(CET_SEL_CTL2, 2'h0, 12'h0, 64'h4000_0001);
    wr(CET_SEL_CTL2, 2'h1, 12'h0, 64'h4000_0002);
    wr(CET_SEL_CTL2, 2'h2, 12'h0, 64'h4000_0001);
    ev(2'h0, CET_SCOPE_SHARED, 1'b0, 2'h3);
    ev(2'h0, CET_SCOPE_SHARED, 1'b1, 2'h3);
    rd("status count", CET_SEL_STATUS, 2'h0, 12'h0, 64'h8000_0080_0000_0000);
    ev(2'h1, CET_SCOPE_CORE, 1'b1, 2'h0);
    ev(2'h1, CET_SCOPE_CORE, 1'b1, 2'h2);
    ev(2'h2, CET_SCOPE_PKG, 1'b0, 2'h3);
    ev(2'h3, CET_SCOPE_PKG, 1'b0, 2'h0);
    ev(2'h0, CET_SCOPE_SYS, 1'b0, 2'h0);
    rd("status after system error", CET_SEL_STATUS, 2'h0, 12'h0, 64'h8000_0080_0000_0000);
    wr(CET_SEL_CTL2, 2'h0, 12'h0, 64'h1);
    ev(2'h0, CET_SCOPE_SHARED, 1'b0, 2'h0);
    wr(CET_SEL_CTL2, 2'h0, 12'h0, 64'h4000_0001);
    wr(CET_SEL_ECTL, 2'h0, 12'h0, 64'h0);
    ev(2'h0, CET_SCOPE_SHARED, 1'b0, 2'h3);
    wr(CET_SEL_STATUS, 2'h0, 12'h0, 64'h0);
    rd("status cleared", CET_SEL_STATUS, 2'h0, 12'h0, 64'h0);
    ev(2'h0, CET_SCOPE_CORE, 1'b0, 2'h1);
    rd("status relogged", CET_SEL_STATUS, 2'h0, 12'h0, 64'h8000_0040_0000_0000);
    // masked entry stops delivery while logging goes on
    wr(CET_SEL_APIC, 2'h0, VEC_OFFSET, 64'h1_0040);
    ev(2'h0, CET_SCOPE_SHARED, 1'b0, 2'h0);
    wr_rd("back to back", 2'h2, 64'h4000_0abc, 64'h4000_0abc);
    for (int i = 0; i < NUM_LP; i++)
      chk("deliveries", 64'(exp_cnt[i]), 64'(lp_cnt[i]));
    test_done;
  end

  // the sequence needs about 100 cycles; this leaves ample margin
  initial begin
    #20000;
    n_fail++;
    test_done;
  end
endmodule
